// ==== include/ddmsp_pkg.sv ====
// Package for the host-side controller of the dual microstep DAC port.
`default_nettype none
package ddmsp_pkg;

   // Select-line encodings for channel and register type.
   localparam logic        CH1_SEL      = 1'b0;
   localparam logic        CH2_SEL      = 1'b1;
   localparam logic        REG_DAC_SEL  = 1'b0;
   localparam logic        REG_LVL_SEL  = 1'b1;

   // Field layout of the data byte.
   localparam int          DATA_W       = 8;
   localparam int          DIR_BIT      = 7;
   localparam int          MAG_W        = 7;
   localparam int          LVL_W        = 3;
   localparam int          LVL_LSB      = 4;

   // Strobe timing in mclk cycles: setup with strobe low, strobe high hold, deselected gap with strobe still high.
   localparam logic [7:0]  SETUP_CYC    = 8'h04;
   localparam logic [7:0]  HOLD_CYC     = 8'h04;
   localparam logic [7:0]  GAP_CYC      = 8'h02;

   // Values shown on the pins after reset.
   localparam logic [7:0]  DATA_RST     = 8'h00;

   // One user request.
   typedef struct packed {
      logic                channel;
      logic                reg_type;
      logic [7:0]          data;
   } ddmsp_req_t;

   // Pins toward the device.
   typedef struct packed {
      logic [7:0]          data;
      logic                write_strobe;
      logic                chip_select_n;
      logic                channel_select;
      logic                register_type_select;
      logic                device_reset;
   } ddmsp_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_HOLD  = 2'b10,
      ST_GAP   = 2'b11
   } ddmsp_state_t;

endpackage
`default_nettype wire

// ==== rtl/ddmsp_shadow.sv ====
// Shadow copy of what the device holds, used to predict its outputs.
`timescale 1ns/10ps
`default_nettype none
module ddmsp_shadow (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 clear,
   input  wire logic                 commit,
   input  wire ddmsp_pkg::ddmsp_req_t req,
   output logic [13:0]               mag_pair,
   output logic [1:0]                dir_pair,
   output logic [1:0]                fast_decay_n_pair
);
   logic [6:0] mag_ff   [2];
   logic [2:0] lvl_ff   [2];
   logic [1:0] dir_ff;
   logic [1:0] fdn_ff;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         wire hit     = commit && (req.channel == 1'(g));
         wire dac_wr  = hit && (req.reg_type == ddmsp_pkg::REG_DAC_SEL);       // [R3]
         wire lvl_wr  = hit && (req.reg_type == ddmsp_pkg::REG_LVL_SEL);       // [R3]
         wire [6:0] new_mag = req.data[6:0];                                   // [R11]
         wire [2:0] new_lvl = req.data[6:4];                                   // [R15]
         // Fast decay only if new value is below both old value and level.
         wire fast = (new_mag < mag_ff[g]) && (new_mag[6:4] < lvl_ff[g]);      // [R8]

         // Clear on reset; a device clear mirrors power-on state.
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               mag_ff[g] <= 7'h00;
               lvl_ff[g] <= 3'h0;
               dir_ff[g] <= 1'b0;
               fdn_ff[g] <= 1'b0;
            end else if (clear) begin
               mag_ff[g] <= 7'h00;                                             // [R6] [R16]
               lvl_ff[g] <= 3'h0;
               dir_ff[g] <= 1'b0;
               fdn_ff[g] <= 1'b0;
            end else if (dac_wr) begin
               mag_ff[g] <= new_mag;
               dir_ff[g] <= req.data[ddmsp_pkg::DIR_BIT];                      // [R5] [R12]
               fdn_ff[g] <= ~fast;                                             // [R7] [R9]
            end else if (lvl_wr) begin
               lvl_ff[g] <= new_lvl;                                           // [R10] [R17]
            end
         end
         assign mag_pair[g*7 +: 7]   = mag_ff[g];
         assign dir_pair[g]          = dir_ff[g];
         assign fast_decay_n_pair[g] = fdn_ff[g];
      end
   endgenerate
endmodule // ddmsp_shadow
`default_nettype wire

// ==== rtl/ddmsp_host.sv ====
// Host controller that writes the dual microstep DAC over its parallel port.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Device latches data on rising write strobe; host raises strobe with data stable.
// R2 - Channel select low targets channel 1, high targets channel 2.
// R3 - Register type select low writes DAC data, high writes decay level.
// R4 - Chip select low held around the strobe rising edge.
// R5 - Direction output follows written data bit 7 without inversion.
// R6 - High device reset clears all device registers; pulled low when unused.
// R7 - Decay output low means fast decay, high means slow decay.
// R8 - Fast decay when new magnitude below old value and below level.
// R9 - Decay output re-evaluated on every DAC data write.
// R10 - Decay level offers eight selectable thresholds.
// R11 - DAC data holds a 7-bit magnitude separate from sign.
// R12 - Direction outputs reverse winding current through the driver.
// R13 - Port is eight data bits, strobe, chip select, two address lines.
// R14 - Each channel has DAC and level registers, comparator, flip-flop, converter.
// R15 - Three-bit level compared against top three magnitude bits.
// R16 - Power-on clears all device flip-flops, outputs start low.
// R17 - Level write leaves DAC data, direction and decay unchanged.
// R18 - Strobe edge with chip select high changes nothing.
module ddmsp_host (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire ddmsp_pkg::ddmsp_req_t req,
   input  wire logic                  clear_req,
   output logic                       done,
   output ddmsp_pkg::ddmsp_pins_t     pins,
   output logic [13:0]                pred_mag,
   output logic [1:0]                 pred_dir,
   output logic [1:0]                 pred_fast_decay_n
);
   ddmsp_pkg::ddmsp_state_t state_ff, nxt_state;
   ddmsp_pkg::ddmsp_req_t   req_ff;
   ddmsp_pkg::ddmsp_pins_t  pins_ff, nxt_pins;
   logic [7:0]              cnt_ff;
   logic                    done_ff;
   logic                    clr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of state and counter.
   wire idle_st  = (state_ff == ddmsp_pkg::ST_IDLE);
   wire cnt_zero = (cnt_ff == 8'h00);
   wire accept   = idle_st && req_valid && !clear_req;
   wire clr_go   = idle_st && clear_req;
   wire rise     = (state_ff == ddmsp_pkg::ST_SETUP) && cnt_zero;  // Strobe rises next, except during a clear.
   wire commit   = (state_ff == ddmsp_pkg::ST_HOLD) && cnt_zero;
   assign req_ready = idle_st && !clear_req;
   assign done      = done_ff;
   assign pins      = pins_ff;

   // Next state: setup with strobe low, then strobe high, then a gap.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ddmsp_pkg::ST_IDLE:  if (accept || clr_go) nxt_state = ddmsp_pkg::ST_SETUP;
         ddmsp_pkg::ST_SETUP: if (cnt_zero) nxt_state = ddmsp_pkg::ST_HOLD;
         ddmsp_pkg::ST_HOLD:  if (cnt_zero) nxt_state = ddmsp_pkg::ST_GAP;
         ddmsp_pkg::ST_GAP:   if (cnt_zero) nxt_state = ddmsp_pkg::ST_IDLE;
         default:             nxt_state = ddmsp_pkg::ST_IDLE;
      endcase
   end

   // Pin values: address and data set a full setup before the strobe edge.
   always_comb begin
      nxt_pins = pins_ff;
      if (accept) begin
         nxt_pins.data                 = req.data;                       // [R13]
         nxt_pins.channel_select       = req.channel;                    // [R2]
         nxt_pins.register_type_select = req.reg_type;                   // [R3]
         nxt_pins.chip_select_n        = 1'b0;                           // [R4]
         nxt_pins.write_strobe         = 1'b0;
      end else if (clr_go) begin
         nxt_pins.device_reset         = 1'b1;                           // [R6]
      end else if (rise && !clr_ff) begin
         nxt_pins.write_strobe         = 1'b1;                           // [R1]
      end else if (commit) begin
         // Chip select released with strobe still high, so only the strobe's falling edge lands deselected.
         nxt_pins.chip_select_n        = 1'b1;                           // [R4] [R18]
         nxt_pins.device_reset         = 1'b0;
      end else if (state_ff == ddmsp_pkg::ST_GAP && cnt_zero) begin
         nxt_pins.write_strobe         = 1'b0;
      end
   end

   wire [7:0] nxt_cnt = (accept || clr_go) ? ddmsp_pkg::SETUP_CYC - 8'h01 :
                        rise               ? ddmsp_pkg::HOLD_CYC - 8'h01 :
                        commit             ? ddmsp_pkg::GAP_CYC - 8'h01 :
                        cnt_zero           ? 8'h00 : cnt_ff - 8'h01;

   // State registers.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ddmsp_pkg::ST_IDLE;
         cnt_ff   <= 8'h00;
         done_ff  <= 1'b0;
         clr_ff   <= 1'b0;
         req_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         done_ff  <= commit;
         if (accept) req_ff <= req;
         if (accept || clr_go) clr_ff <= clr_go;
      end
   end

   // Pin registers; strobe idles low and chip select idles high.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pins_ff.data                 <= ddmsp_pkg::DATA_RST;
         pins_ff.write_strobe         <= 1'b0;
         pins_ff.chip_select_n        <= 1'b1;
         pins_ff.channel_select       <= 1'b0;
         pins_ff.register_type_select <= 1'b0;
         pins_ff.device_reset         <= 1'b0;
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prediction of device outputs, updated when each write completes.
   ddmsp_shadow u_shadow (
      .mclk              (mclk),
      .reset_n           (reset_n),
      .clear             (commit && clr_ff),
      .commit            (commit && !clr_ff),
      .req               (req_ff),
      .mag_pair          (pred_mag),
      .dir_pair          (pred_dir),
      .fast_decay_n_pair (pred_fast_decay_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_cs_at_edge: assert property (@(posedge mclk) disable iff (!reset_n)  // [R4]
      $rose(pins.write_strobe) |-> !pins.chip_select_n)
      else $error("strobe rose with chip select high");
   a_addr_stable: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
      $rose(pins.write_strobe) |-> $stable(pins.data) && $stable(pins.channel_select))
      else $error("data changed at strobe edge");
   a_cs_hold_high: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
      $rose(pins.write_strobe) |-> !pins.chip_select_n [*4])
      else $error("chip select not held after strobe");
   a_chan_route: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
      accept |=> pins.channel_select == $past(req.channel))
      else $error("channel select wrong");
   a_type_route: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
      accept |=> pins.register_type_select == $past(req.reg_type))
      else $error("register type wrong");
   a_dir_pred: assert property (@(posedge mclk) disable iff (!reset_n)   // [R5]
      (commit && !clr_ff && req_ff.reg_type == ddmsp_pkg::REG_DAC_SEL) |=>
         pred_dir[req_ff.channel] == req_ff.data[7])
      else $error("direction prediction wrong");
   a_lvl_keep: assert property (@(posedge mclk) disable iff (!reset_n)   // [R17]
      (commit && req_ff.reg_type == ddmsp_pkg::REG_LVL_SEL && !clr_ff) |=>
         $stable(pred_fast_decay_n) && $stable(pred_mag))
      else $error("level write altered outputs");
   a_reset_clear: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
      (commit && clr_ff) |=> pred_mag == 14'h0000 && pred_fast_decay_n == 2'h0)
      else $error("clear did not zero prediction");
   a_write_time: assert property (@(posedge mclk) disable iff (!reset_n)  // [R1]
      accept |-> ##9 done)
      else $error("write took wrong time");
   c_dac_write: cover property (@(posedge mclk) commit && !req_ff.reg_type);
   c_lvl_write: cover property (@(posedge mclk) commit && req_ff.reg_type);
   c_fast_decay: cover property (@(posedge mclk) $fell(pred_fast_decay_n[0]));
   c_clear: cover property (@(posedge mclk) commit && clr_ff);
endmodule // ddmsp_host
`default_nettype wire

// ==== verification/ddmsp_dev_model.sv ====
// Behavioural model of the dual microstep converter's digital write port.
`timescale 1ns/10ps
`default_nettype none
module ddmsp_dev_model (
   input  wire ddmsp_pkg::ddmsp_pins_t pins,
   output logic [1:0][6:0]             mag_ff,
   output logic [1:0]                  dir_ff,
   output logic [1:0]                  decay_n_ff
);
   logic [1:0][2:0] lvl_ff;
   ////////////////////////////////////////////////////////////////////////////////
   // Comparator: fast decay needs the new code below the old code and the level.
   wire             ch      = pins.channel_select;
   wire       [6:0] new_mag = pins.data[6:0];
   wire             fast    = (new_mag < mag_ff[ch]) && (pins.data[6:4] < lvl_ff[ch]);
   wire             wr      = pins.write_strobe;
   wire             rst     = pins.device_reset;
   ////////////////////////////////////////////////////////////////////////////////
   // Everything starts cleared, as after power-up, so all outputs begin low.
   initial begin
      mag_ff = '0;
      dir_ff = '0;
      decay_n_ff = '0;
      lvl_ff = '0;
   end
   // Writes land at the strobe's rising edge; the falling edge is ignored.
   always @(posedge wr or posedge rst) begin
      if (rst) begin
         mag_ff <= '0;
         dir_ff <= '0;
         decay_n_ff <= '0;
         lvl_ff <= '0;
      end else if (!pins.chip_select_n) begin
         if (pins.register_type_select == ddmsp_pkg::REG_LVL_SEL) begin
            lvl_ff[ch] <= pins.data[6:4];
         end else begin
            mag_ff[ch] <= new_mag;
            dir_ff[ch] <= pins.data[7];
            decay_n_ff[ch] <= ~fast;
         end
      end
   end
endmodule // ddmsp_dev_model
`default_nettype wire

// ==== verification/dual_dac_microstep_port_tb_top.sv ====
// Self-checking testbench for the dual microstep converter host controller.
`timescale 1ns/10ps
`default_nettype none
module dual_dac_microstep_port_tb_top;
   localparam logic        DAC = ddmsp_pkg::REG_DAC_SEL;
   localparam logic        LVL = ddmsp_pkg::REG_LVL_SEL;
   localparam logic        CH1 = ddmsp_pkg::CH1_SEL;
   localparam logic        CH2 = ddmsp_pkg::CH2_SEL;
   logic                   mclk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   req_valid = 1'b0;
   logic                   clear_req = 1'b0;
   ddmsp_pkg::ddmsp_req_t  req = '0;
   logic                   req_ready;
   logic                   done;
   ddmsp_pkg::ddmsp_pins_t pins;
   logic [13:0]            pred_mag;
   logic [1:0]             pred_dir;
   logic [1:0]             pred_dn;
   logic [1:0][6:0]        dev_mag;
   logic [1:0]             dev_dir;
   logic [1:0]             dev_dn;
   logic [1:0][6:0]        e_mag = '0;
   logic [1:0][2:0]        e_lvl = '0;
   logic [1:0]             e_dir = '0;
   logic [1:0]             e_dn = '0;
   int                     errors = 0;
   int                     total_checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Controller under test and the converter it drives.
   ddmsp_host dut_u (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .clear_req(clear_req), .done(done), .pins(pins),
      .pred_mag(pred_mag), .pred_dir(pred_dir), .pred_fast_decay_n(pred_dn));
   ddmsp_dev_model dev_u (.pins(pins), .mag_ff(dev_mag), .dir_ff(dev_dir), .decay_n_ff(dev_dn));
   // Clock of 4 ns period.
   always #2 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Comparison helper; case inequality keeps unknowns from passing.
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One request through the controller, then model and predictions are judged.
   task automatic run_op(input logic clr, input logic ch, input logic rt, input logic [7:0] d);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 20) begin
         @(posedge mclk);
         #1 k++;
      end
      chk("ready", 14'h0001, req_ready);
      req = '{channel: ch, reg_type: rt, data: d};
      clear_req = clr;
      req_valid = !clr;
      @(posedge mclk);
      #1 clear_req = 1'b0;
      req_valid = 1'b0;
      for (k = 0; done !== 1'b1 && k < 20; k++) begin
         // A stray request in mid-transfer must be refused and leave no trace.
         if (k == 3) begin
            chk("ready while busy", 14'h0000, req_ready);
            req.data = ~d;
            req_valid = 1'b1;
         end
         if (k == 4) req_valid = 1'b0;
         @(posedge mclk);
         #1;
      end
      chk("done latency", 14'h0008, 14'(k));
      @(posedge mclk);
      #1 chk("done width", 14'h0000, done);
      if (clr) begin
         e_mag = '0;
         e_lvl = '0;
         e_dir = '0;
         e_dn = '0;
      end else if (rt == LVL) begin
         e_lvl[ch] = d[6:4];
      end else begin
         e_dn[ch] = !((d[6:0] < e_mag[ch]) && (d[6:4] < e_lvl[ch]));
         e_mag[ch] = d[6:0];
         e_dir[ch] = d[7];
      end
      chk("device code", e_mag, dev_mag);
      chk("predicted code", e_mag, pred_mag);
      chk("device direction", 14'(e_dir), 14'(dev_dir));
      chk("predicted direction", 14'(e_dir), 14'(pred_dir));
      chk("device decay", 14'(e_dn), 14'(dev_dn));
      chk("predicted decay", 14'(e_dn), 14'(pred_dn));
   endtask
   // Prints the counts and the verdict, then stops the run.
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: idle pins, every threshold, boundary codes, a device clear, then one more write.
   initial begin
      repeat (8) @(posedge mclk);
      #1 reset_n = 1'b1;
      chk("idle select", 14'h0001, 14'(pins.chip_select_n));
      chk("idle strobe", 14'h0000, 14'(pins.write_strobe));
      chk("idle reset", 14'h0000, 14'(pins.device_reset));
      chk("power-up code", 14'h0000, dev_mag);
      run_op(1'b0, CH1, DAC, 8'h85);
      run_op(1'b0, CH2, DAC, 8'h7F);
      for (int i = 0; i < 8; i++) begin
         run_op(1'b0, CH2, LVL, {1'b0, i[2:0], 4'h0});
         run_op(1'b0, CH2, DAC, 8'h7F);
         run_op(1'b0, CH2, DAC, {1'b1, i[2:0], 4'hF});
         run_op(1'b0, CH2, DAC, {1'b0, 3'(i - 1), 4'hF});
      end
      run_op(1'b0, CH1, LVL, 8'h70);
      run_op(1'b0, CH1, DAC, 8'h05);
      run_op(1'b0, CH1, DAC, 8'h04);
      run_op(1'b0, CH1, LVL, 8'h00);
      run_op(1'b1, CH1, DAC, 8'h00);
      run_op(1'b0, CH1, DAC, 8'h01);
      finish_test();
   end
   // Watchdog: about forty transfers of eleven cycles fit well inside this span.
   initial begin
      #20000;
      errors++;
      finish_test();
   end
endmodule // dual_dac_microstep_port_tb_top
`default_nettype wire
